// ==== shared/ccs_pkg.sv ====
package ccs_pkg;

    // sequencer timing: one step t, derived from the system clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_NS = 25000;
    localparam int SEQ_DIV = 64;
    localparam int STEP_CYC = STEP_NS / CLK_PERIOD_NS;
    localparam int HALF_STEP_CYC = STEP_CYC / 2;
    localparam int FINE_CYC = STEP_CYC / SEQ_DIV;
    localparam logic [10:0] HALF_STEP_LAST = 11'(HALF_STEP_CYC - 1);
    localparam logic [10:0] FINE_LAST = 11'(FINE_CYC - 1);

    // activation milestones, half steps counted from the previous milestone
    localparam logic [3:0] RISE_VCC_HALVES = 4'h5;
    localparam logic [3:0] RISE_IO_HALVES = 4'h4;
    localparam logic [3:0] RISE_CLK_HALVES = 4'h1;
    // deactivation milestones, half steps counted from the previous milestone
    localparam logic [3:0] FALL_CLK_HALVES = 4'h1;
    localparam logic [3:0] FALL_IO_HALVES = 4'h1;
    localparam logic [3:0] FALL_VCC_HALVES = 4'h1;
    localparam logic [3:0] FALL_DCDC_HALVES = 4'h4;
    localparam logic [3:0] HALVES_MAX = 4'hf;

    // last count of the card clock half period, which is one more system clock cycle
    localparam logic [3:0] CARD_CLK_HALF_LAST = 4'h3;

    // register byte addresses
    localparam logic [7:0] PCR_ADDR = 8'h00;
    localparam logic [7:0] HSR_ADDR = 8'h04;

    // power control register fields
    localparam int PCR_START = 0;
    localparam int PCR_VCC_THREE = 1;
    localparam int PCR_RST_LEVEL = 2;
    localparam int PCR_VCC_LOW = 3;
    localparam int PCR_AUX_A = 4;
    localparam int PCR_AUX_B = 5;
    localparam logic [7:0] PCR_RESET = 8'h30;

    // hardware status register fields
    localparam int HSR_OVERTEMP = 0;
    localparam int HSR_PRESENT = 1;
    localparam int HSR_CARD_PRESENT_IN_CHANGE = 2;
    localparam int HSR_SUPPLY_LOW = 4;
    localparam int HSR_OVERCURRENT = 5;
    localparam logic SUPPLY_LOW_RESET = 1'b1;

    // card supply level codes
    localparam logic [1:0] VCC_LEVEL_5V = 2'h0;
    localparam logic [1:0] VCC_LEVEL_3V = 2'h1;
    localparam logic [1:0] VCC_LEVEL_1V8 = 2'h2;

    typedef enum logic [3:0] {
        CCS_IDLE = 4'h0,
        CCS_CONV_ON = 4'h1,
        CCS_VCC_ON = 4'h2,
        CCS_IO_UP = 4'h3,
        CCS_ACTIVE = 4'h4,
        CCS_DEACT_WAIT = 4'h5,
        CCS_RST_LOW = 4'h6,
        CCS_CLK_LOW = 4'h7,
        CCS_IO_LOW = 4'h8,
        CCS_VCC_LOW = 4'h9
    } ccs_state_t;

endpackage

// ==== rtl/ccs_step_timer.sv ====
`timescale 1ns/1ps
module ccs_step_timer
    import ccs_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic restart, // restart timing from zero
    output logic [3:0] half_count, // half steps since restart, saturating
    output logic fine_done // one sixty-fourth step elapsed since restart
);

    logic [10:0] cyc;

    // divides the system clock into half steps of the sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cyc <= 11'h000;
            half_count <= 4'h0;
        end else if (restart) begin
            cyc <= 11'h000;
            half_count <= 4'h0;
        end else if (cyc == HALF_STEP_LAST) begin
            cyc <= 11'h000;
            if (half_count != HALVES_MAX) begin
                half_count <= half_count + 4'h1;
            end
        end else begin
            cyc <= cyc + 11'h001;
        end
    end

    // marks the first fine tick after a restart
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fine_done <= 1'b0;
        end else if (restart) begin
            fine_done <= 1'b0;
        end else if (cyc == FINE_LAST) begin
            fine_done <= 1'b1;
        end
    end

endmodule // ccs_step_timer

// ==== rtl/ccs_top.sv ====
`timescale 1ns/1ps
module ccs_top
    import ccs_pkg::*;
(
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic rst, // async reset, active high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire logic card_present_in, // card presence, high when inserted
    input wire logic vcc_overcurrent_in, // supply current at limit
    input wire logic rst_overcurrent_in, // reset contact current at limit
    input wire logic overtemp_in, // die temperature too high
    input wire logic supply_alarm_in, // supervisor alarm pulse
    input wire logic reset_pin_in, // external reset pin, active high
    input wire logic uart_int_req, // card uart wants the interrupt line
    input wire logic etu_int_req, // etu counters want the interrupt line
    input wire logic aux_contact_a_i, // aux contact a pin level
    input wire logic aux_contact_b_i, // aux contact b pin level
    output logic aux_contact_a_o, // aux contact a drive value
    output logic aux_contact_a_oe, // aux contact a drive enable
    output logic aux_contact_b_o, // aux contact b drive value
    output logic aux_contact_b_oe, // aux contact b drive enable
    output logic dcdc_en, // dc-to-dc converter running
    output logic vcc_en, // card supply raised
    output logic [1:0] vcc_level, // selected supply level
    output logic card_clk, // clock to the card
    output logic card_rst, // reset contact level
    output logic io_pullup_en, // pull-ups on i/o and aux contacts
    output logic io_ground, // i/o contact driven to 0 v
    output logic card_ground, // all contacts low-impedance to ground
    output logic chip_reset_req, // pulse asking for a full chip reset
    output logic card_event_n // card event interrupt, active low
);

    ccs_state_t state;
    ccs_state_t next_state;
    logic [3:0] half_count;
    logic fine_done;
    logic timer_restart;

    logic start_bit;
    logic vcc_three_select;
    logic card_reset_level_bit;
    logic vcc_low_select;
    logic aux_a_bit;
    logic aux_b_bit;

    logic presence_change_flag;
    logic overcurrent_flag;
    logic overtemp_flag;
    logic supply_low_flag;
    logic present_prev;
    logic hist_valid;
    logic alarm_prev;
    logic drop_prev;
    logic drop_pending;

    logic next_vcc;
    logic next_pull;
    logic next_clk_run;
    logic next_rst_en;
    logic clk_run;
    logic rst_en;
    logic [3:0] clk_div;

    logic bus_req;
    logic bus_take;
    logic pcr_write;
    logic hsr_read;
    logic emergency;
    logic abort;
    logic start_allowed;
    logic [7:0] pcr_view;
    logic [7:0] hsr_view;

    // address decode shared by read and write paths
    function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] target);
        addr_is = (adr == target);
    endfunction

    // wishbone request taken once, in the cycle before ack rises
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_take = bus_req & ~wb_ack_o;
    assign pcr_write = bus_take & wb_we_i & wb_sel_i[0] & addr_is(wb_adr_i, PCR_ADDR);
    assign hsr_read = bus_take & ~wb_we_i & addr_is(wb_adr_i, HSR_ADDR);

    // emergency sources and activation permission
    assign emergency = ~card_present_in | vcc_overcurrent_in | rst_overcurrent_in
        | overtemp_in | supply_alarm_in | reset_pin_in;
    assign start_allowed = card_present_in & ~supply_alarm_in;
    assign abort = ~start_bit | emergency;

    // register images as software sees them
    assign pcr_view = {2'b00, aux_contact_b_i, aux_contact_a_i, vcc_low_select,
        card_reset_level_bit, vcc_three_select, start_bit};
    assign hsr_view = {2'b00, overcurrent_flag, supply_low_flag, 1'b0,
        presence_change_flag, card_present_in, overtemp_flag};

    // half-step timebase, restarted at every state change
    assign timer_restart = (next_state != state);

    ccs_step_timer u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(timer_restart),
        .half_count(half_count),
        .fine_done(fine_done)
    );

    // sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            CCS_IDLE: begin
                if (start_bit && !emergency) begin
                    next_state = CCS_CONV_ON;
                end
            end
            CCS_CONV_ON: begin
                if (abort) begin
                    next_state = CCS_DEACT_WAIT;
                end else if (half_count >= RISE_VCC_HALVES) begin
                    next_state = CCS_VCC_ON;
                end
            end
            CCS_VCC_ON: begin
                if (abort) begin
                    next_state = CCS_DEACT_WAIT;
                end else if (half_count >= RISE_IO_HALVES) begin
                    next_state = CCS_IO_UP;
                end
            end
            CCS_IO_UP: begin
                if (abort) begin
                    next_state = CCS_DEACT_WAIT;
                end else if (half_count >= RISE_CLK_HALVES) begin
                    next_state = CCS_ACTIVE;
                end
            end
            CCS_ACTIVE: begin
                if (abort) begin
                    next_state = CCS_DEACT_WAIT;
                end
            end
            CCS_DEACT_WAIT: begin
                if (fine_done) begin
                    next_state = CCS_RST_LOW;
                end
            end
            CCS_RST_LOW: begin
                if (half_count >= FALL_CLK_HALVES) begin
                    next_state = CCS_CLK_LOW;
                end
            end
            CCS_CLK_LOW: begin
                if (half_count >= FALL_IO_HALVES) begin
                    next_state = CCS_IO_LOW;
                end
            end
            CCS_IO_LOW: begin
                if (half_count >= FALL_VCC_HALVES) begin
                    next_state = CCS_VCC_LOW;
                end
            end
            CCS_VCC_LOW: begin
                if (half_count >= FALL_DCDC_HALVES) begin
                    next_state = CCS_IDLE;
                end
            end
            default: begin
                next_state = CCS_IDLE;
            end
        endcase
    end

    // sequencer state register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= CCS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // contact controls: set at activation milestones, cleared at deactivation ones
    always_comb begin
        next_vcc = vcc_en;
        next_pull = io_pullup_en;
        next_clk_run = clk_run;
        next_rst_en = rst_en;
        if (next_state == CCS_IDLE) begin
            next_vcc = 1'b0;
            next_pull = 1'b0;
            next_clk_run = 1'b0;
            next_rst_en = 1'b0;
        end else if (next_state != state) begin
            case (next_state)
                CCS_VCC_ON: next_vcc = 1'b1;
                CCS_IO_UP: next_pull = 1'b1;
                CCS_ACTIVE: begin
                    next_clk_run = 1'b1;
                    next_rst_en = 1'b1;
                end
                CCS_RST_LOW: next_rst_en = 1'b0;
                CCS_CLK_LOW: next_clk_run = 1'b0;
                CCS_IO_LOW: next_pull = 1'b0;
                CCS_VCC_LOW: next_vcc = 1'b0;
                default: next_vcc = vcc_en;
            endcase
        end
    end

    // registered contact outputs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dcdc_en <= 1'b0;
            vcc_en <= 1'b0;
            io_pullup_en <= 1'b0;
            io_ground <= 1'b1;
            card_ground <= 1'b1;
            clk_run <= 1'b0;
            rst_en <= 1'b0;
            card_rst <= 1'b0;
        end else begin
            dcdc_en <= (next_state != CCS_IDLE);
            vcc_en <= next_vcc;
            io_pullup_en <= next_pull;
            io_ground <= ~next_pull;
            card_ground <= (next_state == CCS_IDLE);
            clk_run <= next_clk_run;
            rst_en <= next_rst_en;
            card_rst <= next_rst_en & card_reset_level_bit;
        end
    end

    // aux contacts: pulled up while active, pulled low by a zero bit, else grounded
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aux_contact_a_o <= 1'b0;
            aux_contact_b_o <= 1'b0;
            aux_contact_a_oe <= 1'b1;
            aux_contact_b_oe <= 1'b1;
        end else begin
            aux_contact_a_o <= 1'b0;
            aux_contact_b_o <= 1'b0;
            aux_contact_a_oe <= ~(next_pull & aux_a_bit);
            aux_contact_b_oe <= ~(next_pull & aux_b_bit);
        end
    end

    // card clock divider, forced low when stopped
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_div <= 4'h0;
            card_clk <= 1'b0;
        end else if (!next_clk_run) begin
            clk_div <= 4'h0;
            card_clk <= 1'b0;
        end else if (clk_div == CARD_CLK_HALF_LAST) begin
            clk_div <= 4'h0;
            card_clk <= ~card_clk;
        end else begin
            clk_div <= clk_div + 4'h1;
        end
    end

    // supply level selection, the 1.8 v bit takes precedence
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vcc_level <= VCC_LEVEL_5V;
        end else if (vcc_low_select) begin
            vcc_level <= VCC_LEVEL_1V8;
        end else if (vcc_three_select) begin
            vcc_level <= VCC_LEVEL_3V;
        end else begin
            vcc_level <= VCC_LEVEL_5V;
        end
    end

    // start bit: gated on write, cleared by any emergency
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            start_bit <= PCR_RESET[PCR_START];
        end else if (emergency) begin
            start_bit <= 1'b0;
        end else if (pcr_write) begin
            if (!wb_dat_i[PCR_START]) begin
                start_bit <= 1'b0;
            end else if (start_allowed) begin
                start_bit <= 1'b1;
            end
        end
    end

    // remaining power control bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vcc_three_select <= PCR_RESET[PCR_VCC_THREE];
            card_reset_level_bit <= PCR_RESET[PCR_RST_LEVEL];
            vcc_low_select <= PCR_RESET[PCR_VCC_LOW];
            aux_a_bit <= PCR_RESET[PCR_AUX_A];
            aux_b_bit <= PCR_RESET[PCR_AUX_B];
        end else if (pcr_write) begin
            vcc_three_select <= wb_dat_i[PCR_VCC_THREE];
            card_reset_level_bit <= wb_dat_i[PCR_RST_LEVEL];
            vcc_low_select <= wb_dat_i[PCR_VCC_LOW];
            aux_a_bit <= wb_dat_i[PCR_AUX_A];
            aux_b_bit <= wb_dat_i[PCR_AUX_B];
        end
    end

    // edge history of presence, alarm and drop-out sources
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            present_prev <= 1'b0;
            alarm_prev <= 1'b0;
            drop_prev <= 1'b0;
            hist_valid <= 1'b0;
        end else begin
            hist_valid <= 1'b1; // no presence edge in the first cycle after reset
            present_prev <= card_present_in;
            alarm_prev <= supply_alarm_in;
            drop_prev <= supply_alarm_in | reset_pin_in;
        end
    end

    // sticky status flags, a new event beats the clearing read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            presence_change_flag <= 1'b0;
            overcurrent_flag <= 1'b0;
            overtemp_flag <= 1'b0;
        end else begin
            if (hist_valid && (card_present_in != present_prev)) begin
                presence_change_flag <= 1'b1;
            end else if (hsr_read) begin
                presence_change_flag <= 1'b0;
            end
            if (vcc_overcurrent_in | rst_overcurrent_in) begin
                overcurrent_flag <= 1'b1;
            end else if (hsr_read) begin
                overcurrent_flag <= 1'b0;
            end
            if (overtemp_in) begin
                overtemp_flag <= 1'b1;
            end else if (hsr_read) begin
                overtemp_flag <= 1'b0;
            end
        end
    end

    // supply-low flag: set after reset and on recovery, read clears outside alarm
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            supply_low_flag <= SUPPLY_LOW_RESET;
        end else if (alarm_prev & ~supply_alarm_in) begin
            supply_low_flag <= 1'b1;
        end else if (hsr_read & ~supply_alarm_in) begin
            supply_low_flag <= 1'b0;
        end
    end

    // drop-out or reset pin: chip reset once deactivation has finished
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drop_pending <= 1'b0;
            chip_reset_req <= 1'b0;
        end else begin
            chip_reset_req <= 1'b0;
            if ((supply_alarm_in | reset_pin_in) & ~drop_prev) begin
                drop_pending <= 1'b1;
            end else if (drop_pending && state == CCS_IDLE) begin
                drop_pending <= 1'b0;
                chip_reset_req <= 1'b1;
            end
        end
    end

    // shared card event line, held low while any source asks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            card_event_n <= 1'b0;
        end else begin
            card_event_n <= ~(presence_change_flag | overcurrent_flag | overtemp_flag
                | supply_low_flag | uart_int_req | etu_int_req);
        end
    end

    // wishbone slave: one wait state, unmapped reads return zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_take;
            if (bus_take) begin
                if (wb_we_i) begin
                    wb_dat_o <= 32'h0000_0000;
                end else if (addr_is(wb_adr_i, PCR_ADDR)) begin
                    wb_dat_o <= {24'h00_0000, pcr_view};
                end else if (addr_is(wb_adr_i, HSR_ADDR)) begin
                    wb_dat_o <= {24'h00_0000, hsr_view};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

endmodule // ccs_top

// ==== tb/ccs_props.sv ====
`timescale 1ns/1ps
module ccs_props (
    input wire logic sys_clk, // clock
    input wire logic rst, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_ack_o, // ack
    input wire logic overtemp_in, // heat fault
    input wire logic uart_int_req, // uart source
    input wire logic dcdc_en, // converter
    input wire logic vcc_en, // supply
    input wire logic card_clk, // card clock
    input wire logic card_rst, // card reset
    input wire logic io_pullup_en, // pull-ups
    input wire logic card_ground, // idle ground
    input wire logic chip_reset_req, // chip reset
    input wire logic card_event_n // interrupt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // supply held off while the converter settles
    sequence s_vcc_held;
        !vcc_en [*8];
    endsequence
    // contact order, bus answer, interrupt line, heat stop and chip reset
    idle_contacts_a: assert property (
        card_ground |-> !(dcdc_en || vcc_en || card_clk || card_rst || io_pullup_en))
        else $error("contact live while idle");
    clk_order_a: assert property (
        card_clk |-> io_pullup_en && vcc_en && dcdc_en) else $error("clock before supply");
    supply_fall_a: assert property (
        $fell(vcc_en) |-> !card_clk && !io_pullup_en && dcdc_en) else $error("early fall");
    conv_lead_a: assert property (
        $rose(dcdc_en) |=> s_vcc_held) else $error("supply with converter");
    bus_answer_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    line_share_a: assert property (
        uart_int_req |-> ##[1:2] !card_event_n) else $error("line not shared");
    heat_stop_a: assert property (
        overtemp_in && card_rst |-> ##[1:60] !card_rst) else $error("no stop on heat");
    chip_reset_a: assert property (
        chip_reset_req |-> card_ground && !vcc_en) else $error("chip reset while live");
endmodule // ccs_props
bind ccs_top ccs_props i_ccs_props (.*);

// ==== tb/ccs_card_model.sv ====
`timescale 1ns/1ps
module ccs_card_model (
    input wire logic card_clk, // card clock
    input wire logic vcc_en, // card supply
    input wire logic io_pullup_en, // pull-ups on
    input wire logic a_oe, // aux a pulled low
    input wire logic b_oe, // aux b pulled low
    output logic a_pin, // aux a wire
    output logic b_pin, // aux b wire
    output int clk_count // pulses seen
);
    // pull-ups reach the card supply only while it is up
    assign a_pin = !a_oe && io_pullup_en && vcc_en;
    assign b_pin = !b_oe && io_pullup_en && vcc_en;
    // count card clock pulses before reset may rise
    always_ff @(posedge card_clk or negedge vcc_en) begin
        if (!vcc_en) begin
            clk_count <= 0;
        end else begin
            clk_count <= clk_count + 1;
        end
    end
endmodule // ccs_card_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import ccs_pkg::*;
();
    logic sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic [3:0] wb_sel_i = 0;
    logic card_present_in = 1, vcc_overcurrent_in = 0, rst_overcurrent_in = 0, overtemp_in = 0;
    logic supply_alarm_in = 0, reset_pin_in = 0, uart_int_req = 0, etu_int_req = 0;
    logic aux_contact_a_i, aux_contact_b_i, aux_contact_a_o, aux_contact_a_oe;
    logic aux_contact_b_o, aux_contact_b_oe, dcdc_en, vcc_en, card_clk, card_rst;
    logic io_pullup_en, io_ground, card_ground, chip_reset_req, card_event_n;
    logic [1:0] vcc_level;
    int mismatches = 0, compares = 0, cycles = 0, n, clk_count;
    wire [6:0] probe = {chip_reset_req, card_ground, card_rst, card_clk, io_pullup_en,
        vcc_en, dcdc_en};
    ccs_top i_ccs_top (.*);
    ccs_card_model i_ccs_card_model (.card_clk, .vcc_en, .io_pullup_en, .a_oe(aux_contact_a_oe),
        .b_oe(aux_contact_b_oe), .a_pin(aux_contact_a_i), .b_pin(aux_contact_b_i), .clk_count);
    // clock and hang limit
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            mismatches++;
            close_out();
        end
    end
    // report and end the run
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rng(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[ERR] %0t delay %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // one classic wishbone cycle, read data into q
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic wait_bit(input int i, input logic v);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (probe[i] !== v);
    endtask
    // activation milestones, then reset level raised
    task automatic activate(input logic [7:0] v, input logic [1:0] lvl);
        wb(1'h0, HSR_ADDR, 0);
        chk(q, 32'h0000_0002);
        wb(1'h1, PCR_ADDR, {24'h00_0000, v});
        wait_bit(0, 1'h1);
        rng(n, 1, 3 * FINE_CYC);
        chk(vcc_level, lvl);
        wait_bit(1, 1'h1);
        rng(n, 5 * HALF_STEP_CYC, 5 * HALF_STEP_CYC + 16);
        wait_bit(2, 1'h1);
        rng(n, 4 * HALF_STEP_CYC, 4 * HALF_STEP_CYC + 16);
        wait_bit(3, 1'h1);
        rng(n, HALF_STEP_CYC, HALF_STEP_CYC + 16);
        wb(1'h0, PCR_ADDR, 0);
        chk(q, {24'h00_0000, v});
        repeat (64) @(posedge sys_clk);
        chk({card_rst, clk_count > 4}, 2'h1);
        wb(1'h1, PCR_ADDR, {24'h00_0000, v | 8'h04});
        repeat (3) @(posedge sys_clk);
        chk(card_rst, 1'h1);
    endtask
    // deactivation milestones from the trigger
    task automatic deact_times();
        wait_bit(4, 1'h0);
        rng(n, FINE_CYC - 2, FINE_CYC + 8);
        repeat (HALF_STEP_CYC + 8) @(posedge sys_clk);
        chk({card_clk, io_pullup_en}, 2'h1);
        wait_bit(2, 1'h0);
        rng(n, HALF_STEP_CYC - 10, HALF_STEP_CYC + 8);
        chk({io_ground, aux_contact_a_i}, 2'h2);
        wait_bit(1, 1'h0);
        rng(n, HALF_STEP_CYC, HALF_STEP_CYC + 8);
        wait_bit(5, 1'h1);
        rng(n, 4 * HALF_STEP_CYC, 4 * HALF_STEP_CYC + 8);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'h0;
        wb(1'h0, HSR_ADDR, 0);
        chk(q, 32'h0000_0012);
        chk({aux_contact_a_o, aux_contact_b_o, aux_contact_a_oe, aux_contact_b_oe}, 4'h3);
        chk({io_ground, card_ground}, 2'h3);
        wb(1'h0, HSR_ADDR, 0);
        chk(q, 32'h0000_0002);
        wb(1'h0, 8'h08, 0);
        chk(q, 32'h0000_0000);
        chk(card_event_n, 1'h1);
        card_present_in <= 1'h0;
        wb(1'h1, PCR_ADDR, 32'h0000_0031);
        repeat (4) @(posedge sys_clk);
        chk({dcdc_en, card_event_n}, 2'h0);
        card_present_in <= 1'h1;
        uart_int_req <= 1'h1;
        vcc_overcurrent_in <= 1'h1;
        repeat (4) @(posedge sys_clk);
        uart_int_req <= 1'h0;
        vcc_overcurrent_in <= 1'h0;
        wb(1'h0, HSR_ADDR, 0);
        chk(q, 32'h0000_0026);
        etu_int_req <= 1'h1;
        repeat (2) @(posedge sys_clk);
        chk(card_event_n, 1'h0);
        etu_int_req <= 1'h0;
        repeat (2) @(posedge sys_clk);
        chk(card_event_n, 1'h1);
        activate(8'h33, VCC_LEVEL_3V);
        wb(1'h1, PCR_ADDR, 32'h0000_0036);
        deact_times();
        wb(1'h1, PCR_ADDR, 32'h0000_0031);
        wait_bit(0, 1'h1);
        wb(1'h1, PCR_ADDR, 32'h0000_0030);
        wait_bit(5, 1'h1);
        rng(n, 7 * HALF_STEP_CYC + FINE_CYC - 2, 7 * HALF_STEP_CYC + FINE_CYC + 32);
        activate(8'h39, VCC_LEVEL_1V8);
        overtemp_in <= 1'h1;
        deact_times();
        overtemp_in <= 1'h0;
        wb(1'h0, PCR_ADDR, 0);
        chk(q[PCR_START], 1'h0);
        wb(1'h0, HSR_ADDR, 0);
        chk(q, 32'h0000_0003);
        supply_alarm_in <= 1'h1;
        wait_bit(6, 1'h1);
        rng(n, 1, 8);
        supply_alarm_in <= 1'h0;
        repeat (3) @(posedge sys_clk);
        wb(1'h0, HSR_ADDR, 0);
        chk(q, 32'h0000_0012);
        close_out();
    end
endmodule // testbench
